// ---- design/mct_pkg.sv ----
// Constants, types and register map of the maintenance channel transmit
// selector.
// Assumes a single 50 MHz clock and the plain register port of the top.
package mct_pkg;

	// ------------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------------
	localparam int unsigned NIB_W  = 4;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned STAT_W = 2;

	// ------------------------------------------------------------------
	// Register map (word addresses on the register port)
	// ------------------------------------------------------------------
	localparam logic [ADDR_W-1:0] REG_LOW_PRIO  = 4'h0;
	localparam logic [ADDR_W-1:0] REG_HIGH_PRIO = 4'h1;
	localparam logic [ADDR_W-1:0] REG_CTRL      = 4'h2;
	localparam logic [ADDR_W-1:0] REG_STATUS    = 4'h3;
	localparam logic [ADDR_W-1:0] REG_MASK      = 4'h4;
	localparam logic [ADDR_W-1:0] REG_TX_MON    = 4'h5;

	// Field positions
	localparam int unsigned CTRL_TICK_EN = 0;
	localparam int unsigned STAT_TICK    = 0;
	localparam int unsigned STAT_RX_ERR  = 1;
	localparam int unsigned MON_FROM_HI  = 4;
	localparam int unsigned MON_OCC_LSB  = 5;

	// Reset values
	localparam logic [NIB_W-1:0]  LOW_PRIO_RST = 4'h0;
	localparam logic [STAT_W-1:0] STATUS_RST   = 2'h0;
	localparam logic [STAT_W-1:0] MASK_RST     = 2'h0;
	localparam logic              TICK_EN_RST  = 1'b0;
	localparam logic [DATA_W-1:0] RDATA_RST    = 8'h00;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int unsigned CLK_MHZ      = 50;
	localparam int unsigned MF_PERIOD_US = 5000;
	localparam int unsigned TICK_MS      = 30;
	localparam int unsigned MF_CYCLES_DEF = MF_PERIOD_US * CLK_MHZ;
	localparam int unsigned MF_PER_TICK  = TICK_MS * 1000 / MF_PERIOD_US;
	localparam logic [2:0]  MF_IDX_LAST  = 3'(MF_PER_TICK - 1);
	localparam logic [2:0]  MF_IDX_RST   = 3'h0;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		OCC_EMPTY = 3'b001,
		OCC_ONE   = 3'b010,
		OCC_TWO   = 3'b100
	} mct_occ_e;

	typedef struct packed {
		logic             from_high;
		logic [NIB_W-1:0] nibble;
	} mct_tx_s;

	localparam mct_tx_s TX_RST = '{from_high: 1'b0, nibble: 4'h0};

endpackage : mct_pkg

// ---- design/mct_hp_fifo.sv ----
// Two-entry high-priority queue; the oldest entry is the head.
// Assumes push and pop are single-cycle pulses on the one clock.
`timescale 1ns/1ps
module mct_hp_fifo #(
	parameter int unsigned W = mct_pkg::NIB_W
) (
	input  wire logic            clock,
	input  wire logic            rst_b,
	input  wire logic            push,
	input  wire logic [W-1:0]    push_data,
	input  wire logic            pop,
	output logic      [W-1:0]    head,
	output mct_pkg::mct_occ_e    occ,
	output logic                 empty
);

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	logic [W-1:0]      slot [2];
	logic [W-1:0]      next_slot [2];
	mct_pkg::mct_occ_e next_occ;

	always_comb begin
		next_slot[0] = slot[0];
		next_slot[1] = slot[1];
		next_occ     = occ;
		case (occ)
			mct_pkg::OCC_EMPTY: begin
				if (push) begin
					next_slot[0] = push_data;
					next_occ     = mct_pkg::OCC_ONE;
				end
			end
			mct_pkg::OCC_ONE: begin
				if (push && pop) begin
					next_slot[0] = push_data;
				end else if (push) begin
					next_slot[1] = push_data;
					next_occ     = mct_pkg::OCC_TWO;
				end else if (pop) begin
					next_occ     = mct_pkg::OCC_EMPTY;
				end
			end
			mct_pkg::OCC_TWO: begin
				// Full push drops the oldest so an urgent word still goes out
				if (push || pop) begin
					next_slot[0] = slot[1];
				end
				if (push) begin
					next_slot[1] = push_data;
				end else if (pop) begin
					next_occ = mct_pkg::OCC_ONE;
				end
			end
			default: begin
				next_occ = mct_pkg::OCC_EMPTY;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			slot[0] <= '0;
			slot[1] <= '0;
			occ     <= mct_pkg::OCC_EMPTY;
		end else begin
			slot[0] <= next_slot[0];
			slot[1] <= next_slot[1];
			occ     <= next_occ;
		end
	end

	assign head  = slot[0];
	assign empty = (occ == mct_pkg::OCC_EMPTY);

endmodule : mct_hp_fifo

// ---- design/mct_tx_selector.sv ----
// Transmit selector for the first maintenance subchannel of a network
// termination: low-priority register, two-deep high-priority queue,
// multiframe pacing and the 30 ms tick interrupt.
// Assumes a 50 MHz clock, synchronous inputs and a software driver on the
// plain register port.
`timescale 1ns/1ps

module mct_tx_selector #(
	parameter int unsigned MF_CYCLES = mct_pkg::MF_CYCLES_DEF
) (
	input  wire logic                        clock,
	input  wire logic                        rst_b,
	input  wire logic [mct_pkg::ADDR_W-1:0]  reg_addr,
	input  wire logic [mct_pkg::DATA_W-1:0]  reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic      [mct_pkg::DATA_W-1:0]  reg_rdata,
	input  wire logic                        code_violation,
	output mct_pkg::mct_tx_s                 maint_subchannel_a,
	output logic                             tx_strobe,
	output logic                             rx_frame_error_ind,
	output logic                             multiframe_tick_irq,
	output logic                             irq
);

	localparam int unsigned CW = (MF_CYCLES > 1) ? $clog2(MF_CYCLES) : 1;
	localparam logic [CW-1:0] MF_LAST = CW'(MF_CYCLES - 1);

	// ------------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------------
	logic wr_low;
	logic wr_high;
	logic wr_ctrl;
	logic wr_status;
	logic wr_mask;

	assign wr_low    = reg_wr && (reg_addr == mct_pkg::REG_LOW_PRIO);
	assign wr_high   = reg_wr && (reg_addr == mct_pkg::REG_HIGH_PRIO);
	assign wr_ctrl   = reg_wr && (reg_addr == mct_pkg::REG_CTRL);
	assign wr_status = reg_wr && (reg_addr == mct_pkg::REG_STATUS);
	assign wr_mask   = reg_wr && (reg_addr == mct_pkg::REG_MASK);

	// ------------------------------------------------------------------
	// Multiframe and tick timing
	// ------------------------------------------------------------------
	logic [CW-1:0] mf_cnt;
	logic [CW-1:0] next_mf_cnt;
	logic [2:0]    mf_idx;
	logic [2:0]    next_mf_idx;
	logic          mf_boundary;
	logic          tick;

	// Free running so boundaries stay aligned whatever software does
	always_comb begin
		mf_boundary = (mf_cnt == MF_LAST);
		tick        = mf_boundary && (mf_idx == mct_pkg::MF_IDX_LAST);
		next_mf_cnt = mf_boundary ? '0 : mf_cnt + 1'b1;
		next_mf_idx = mf_idx;
		if (mf_boundary) begin
			next_mf_idx = (mf_idx == mct_pkg::MF_IDX_LAST) ?
				mct_pkg::MF_IDX_RST : mf_idx + 3'h1;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			mf_cnt <= '0;
			mf_idx <= mct_pkg::MF_IDX_RST;
		end else begin
			mf_cnt <= next_mf_cnt;
			mf_idx <= next_mf_idx;
		end
	end

	// ------------------------------------------------------------------
	// High-priority queue
	// ------------------------------------------------------------------
	logic [mct_pkg::NIB_W-1:0] hp_head;
	mct_pkg::mct_occ_e         hp_occ;
	logic                      hp_empty;
	logic                      hp_pop;

	assign hp_pop = mf_boundary && !hp_empty;

	mct_hp_fifo #(
		.W         (mct_pkg::NIB_W)
	) u_maint_high_prio_fifo (
		.clock     (clock),
		.rst_b     (rst_b),
		.push      (wr_high),
		.push_data (reg_wdata[mct_pkg::NIB_W-1:0]),
		.pop       (hp_pop),
		.head      (hp_head),
		.occ       (hp_occ),
		.empty     (hp_empty)
	);

	// ------------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------------
	logic [mct_pkg::NIB_W-1:0]  maint_low_prio_reg;
	logic [mct_pkg::NIB_W-1:0]  next_low_prio;
	logic                       tick_30ms_enable_cmd;
	logic                       next_tick_en;
	logic [mct_pkg::STAT_W-1:0] status;
	logic [mct_pkg::STAT_W-1:0] next_status;
	logic [mct_pkg::STAT_W-1:0] mask;
	logic [mct_pkg::STAT_W-1:0] next_mask;
	logic [mct_pkg::STAT_W-1:0] events;
	logic [mct_pkg::STAT_W-1:0] clr;

	always_comb begin
		// Low register only changes on a write, so it repeats forever
		next_low_prio = wr_low ? reg_wdata[mct_pkg::NIB_W-1:0] :
			maint_low_prio_reg;
		next_tick_en  = wr_ctrl ? reg_wdata[mct_pkg::CTRL_TICK_EN] :
			tick_30ms_enable_cmd;
		next_mask     = wr_mask ? reg_wdata[mct_pkg::STAT_W-1:0] : mask;
		events = '0;
		events[mct_pkg::STAT_TICK]   = tick && tick_30ms_enable_cmd;
		events[mct_pkg::STAT_RX_ERR] = code_violation;
		clr = wr_status ? reg_wdata[mct_pkg::STAT_W-1:0] : '0;
		// Set wins over a same-cycle write-one clear
		next_status = (status & ~clr) | events;
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			maint_low_prio_reg   <= mct_pkg::LOW_PRIO_RST;
			tick_30ms_enable_cmd <= mct_pkg::TICK_EN_RST;
			status               <= mct_pkg::STATUS_RST;
			mask                 <= mct_pkg::MASK_RST;
		end else begin
			maint_low_prio_reg   <= next_low_prio;
			tick_30ms_enable_cmd <= next_tick_en;
			status               <= next_status;
			mask                 <= next_mask;
		end
	end

	assign irq = |(status & mask);

	// ------------------------------------------------------------------
	// Transmit selection and indications
	// ------------------------------------------------------------------
	mct_pkg::mct_tx_s next_tx;
	logic             next_tx_strobe;
	logic             next_rx_err;
	logic             next_tick_irq;

	always_comb begin
		next_tx = maint_subchannel_a;
		if (mf_boundary) begin
			if (!hp_empty) begin
				next_tx.from_high = 1'b1;
				next_tx.nibble    = hp_head;
			end else begin
				next_tx.from_high = 1'b0;
				next_tx.nibble    = maint_low_prio_reg;
			end
		end
		next_tx_strobe = mf_boundary;
		next_rx_err    = code_violation;
		next_tick_irq  = tick && tick_30ms_enable_cmd;
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			maint_subchannel_a  <= mct_pkg::TX_RST;
			tx_strobe           <= 1'b0;
			rx_frame_error_ind  <= 1'b0;
			multiframe_tick_irq <= 1'b0;
		end else begin
			maint_subchannel_a  <= next_tx;
			tx_strobe           <= next_tx_strobe;
			rx_frame_error_ind  <= next_rx_err;
			multiframe_tick_irq <= next_tick_irq;
		end
	end

	// ------------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------------
	logic [mct_pkg::DATA_W-1:0] next_rdata;
	logic [1:0]                 occ_count;

	always_comb begin
		case (hp_occ)
			mct_pkg::OCC_ONE: occ_count = 2'h1;
			mct_pkg::OCC_TWO: occ_count = 2'h2;
			default:          occ_count = 2'h0;
		endcase
		next_rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				mct_pkg::REG_LOW_PRIO:
					next_rdata[mct_pkg::NIB_W-1:0] = maint_low_prio_reg;
				mct_pkg::REG_HIGH_PRIO:
					next_rdata[mct_pkg::NIB_W-1:0] = hp_head;
				mct_pkg::REG_CTRL:
					next_rdata[mct_pkg::CTRL_TICK_EN] = tick_30ms_enable_cmd;
				mct_pkg::REG_STATUS:
					next_rdata[mct_pkg::STAT_W-1:0] = status;
				mct_pkg::REG_MASK:
					next_rdata[mct_pkg::STAT_W-1:0] = mask;
				mct_pkg::REG_TX_MON: begin
					next_rdata[mct_pkg::NIB_W-1:0] = maint_subchannel_a.nibble;
					next_rdata[mct_pkg::MON_FROM_HI] =
						maint_subchannel_a.from_high;
					next_rdata[mct_pkg::MON_OCC_LSB +: 2] = occ_count;
				end
				default: next_rdata = '0;
			endcase
		end
	end

	// Unmapped or idle cycles read back zero
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= mct_pkg::RDATA_RST;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

endmodule : mct_tx_selector

// ---- sim/mct_tx_selector_properties.sv ----
// Checker of the transmit selector, on the top module's ports only.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
module mct_tx_selector_properties #(
	parameter int unsigned MF_CYCLES = mct_pkg::MF_CYCLES_DEF
) (
	input wire logic                       clock,
	input wire logic                       rst_b,
	input wire logic [mct_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [mct_pkg::DATA_W-1:0] reg_wdata,
	input wire logic                       reg_wr,
	input wire logic                       reg_rd,
	input wire logic [mct_pkg::DATA_W-1:0] reg_rdata,
	input wire logic                       code_violation,
	input wire mct_pkg::mct_tx_s           maint_subchannel_a,
	input wire logic                       tx_strobe,
	input wire logic                       rx_frame_error_ind,
	input wire logic                       multiframe_tick_irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);

	// Cycles since last frame, frames mod 6, queue push seen before boundary
	int unsigned since_tx, next_since_tx, n_mf, next_n_mf;
	logic        hp_pend, next_hp_pend;
	always_comb begin
		next_since_tx = tx_strobe ? 1 : since_tx + 1;
		next_n_mf = tx_strobe ? ((n_mf == 5) ? 0 : n_mf + 1) : n_mf;
		next_hp_pend = (reg_wr && reg_addr == mct_pkg::REG_HIGH_PRIO &&
			since_tx != MF_CYCLES - 1) || (hp_pend && !tx_strobe);
	end
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			since_tx <= 0;
			n_mf     <= 0;
			hp_pend  <= 1'b0;
		end else begin
			since_tx <= next_since_tx;
			n_mf     <= next_n_mf;
			hp_pend  <= next_hp_pend;
		end
	end

	sequence low_write;
		reg_wr && reg_addr == mct_pkg::REG_LOW_PRIO;
	endsequence
	sequence low_read;
		reg_rd && reg_addr == mct_pkg::REG_LOW_PRIO;
	endsequence

	mf_period_a: assert property (
		tx_strobe == (since_tx == MF_CYCLES)) else $error("frame period off");
	frame_stable_a: assert property (
		!tx_strobe |-> $stable(maint_subchannel_a))
		else $error("frame changed mid multiframe");
	tick_every_six_a: assert property (
		multiframe_tick_irq |-> tx_strobe && n_mf == 5)
		else $error("tick not on sixth multiframe");
	err_follows_a: assert property (
		code_violation |=> rx_frame_error_ind) else $error("error ind missed");
	err_cause_a: assert property (
		rx_frame_error_ind |-> $past(code_violation))
		else $error("error ind without cause");
	rdata_idle_a: assert property (
		!reg_rd |=> reg_rdata == 8'h00) else $error("read data not zero");
	low_reg_hold_a: assert property (low_write ##1 low_read |=>
		reg_rdata == {4'h0, $past(reg_wdata[3:0], 2)})
		else $error("low register read back wrong");
	queue_first_a: assert property (
		tx_strobe && hp_pend |-> maint_subchannel_a.from_high)
		else $error("queued word not sent first");
endmodule : mct_tx_selector_properties

bind mct_tx_selector mct_tx_selector_properties #(.MF_CYCLES(MF_CYCLES)) u_prop (
	.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .code_violation(code_violation),
	.maint_subchannel_a(maint_subchannel_a), .tx_strobe(tx_strobe),
	.rx_frame_error_ind(rx_frame_error_ind),
	.multiframe_tick_irq(multiframe_tick_irq));

// ---- sim/mct_te_model.sv ----
// Terminal-side model: keeps the last frame of the first subchannel.
// Assumes tx_strobe marks each new frame on the selector's output.
`timescale 1ns/1ps
module mct_te_model (
	input  wire logic             clock,
	input  wire logic             rst_b,
	input  wire mct_pkg::mct_tx_s maint_subchannel_a,
	input  wire logic             tx_strobe,
	output mct_pkg::mct_tx_s      last_rx
);
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			last_rx <= mct_pkg::TX_RST;
		else if (tx_strobe)
			last_rx <= maint_subchannel_a;
	end
endmodule : mct_te_model

// ---- sim/mct_tx_selector_tb_top.sv ----
// Bench of the transmit selector: register tasks, frame checks, verdict.
// Assumes the checker bind and the terminal model are compiled alongside.
`timescale 1ns/1ps
module mct_tx_selector_tb_top;
	localparam int unsigned MF = 20;
	// Message codes are arbitrary; only that they differ matters here
	localparam logic [3:0] UPLINK = 4'h1;
	localparam logic [3:0] FAR_VIOL = 4'h2;
	localparam logic [3:0] OUTAGE = 4'h3;
	localparam logic [3:0] PWR_LOSS = 4'h5;
	logic             clock = 1'b0;
	logic             rst_b = 1'b0;
	logic [3:0]       reg_addr = 4'h0;
	logic [7:0]       reg_wdata = 8'h00;
	logic             reg_wr = 1'b0;
	logic             reg_rd = 1'b0;
	logic             code_violation = 1'b0;
	logic [7:0]       reg_rdata;
	mct_pkg::mct_tx_s tx, last_rx;
	logic             tx_strobe, rx_err, irq, tick_irq;
	logic [3:0]       zero_regs [5] = '{mct_pkg::REG_LOW_PRIO,
		mct_pkg::REG_CTRL, mct_pkg::REG_STATUS, mct_pkg::REG_MASK, 4'hf};
	int               n_fail = 0;
	int               compares = 0;
	int               cycles = 0;

	always #10 clock = ~clock;

	mct_tx_selector #(.MF_CYCLES(MF)) DUT (
		.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .code_violation(code_violation),
		.maint_subchannel_a(tx), .tx_strobe(tx_strobe),
		.rx_frame_error_ind(rx_err), .multiframe_tick_irq(tick_irq),
		.irq(irq));
	mct_te_model te (.clock(clock), .rst_b(rst_b),
		.maint_subchannel_a(tx), .tx_strobe(tx_strobe), .last_rx(last_rx));

	task automatic summarize();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize

	task automatic chk8(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s exp %h got %h", what, exp, got);
		end
	endtask : chk8

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr

	// Write then read back in the very next cycle, no idle gap
	task automatic wr_rd(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 chk8("rdata", d, reg_rdata);
	endtask : wr_rd

	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 chk8("rdata", exp, reg_rdata);
	endtask : rd

	// Waits for the next frame, then compares what the terminal took
	task automatic frame(input logic hi, input logic [3:0] nib);
		int i;
		#1;
		for (i = 0; i < 2 * MF && tx_strobe !== 1'b1; i++) begin
			@(posedge clock);
			#1;
		end
		@(posedge clock);
		#1 chk8("frame", {3'h0, hi, nib}, {3'h0, last_rx});
	endtask : frame

	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			n_fail++;
			summarize();
		end
	end

	initial begin
		int i;
		repeat (5) @(posedge clock);
		rst_b <= 1'b1;
		foreach (zero_regs[k]) rd(zero_regs[k], 8'h00);
		wr_rd(mct_pkg::REG_LOW_PRIO, {4'h0, OUTAGE});
		frame(1'b0, OUTAGE);
		frame(1'b0, OUTAGE);
		repeat (4) frame(1'b0, OUTAGE);
		wr(mct_pkg::REG_HIGH_PRIO, {4'h0, UPLINK});
		wr(mct_pkg::REG_HIGH_PRIO, {4'h0, FAR_VIOL});
		rd(mct_pkg::REG_TX_MON, {3'h2, 1'b0, OUTAGE});
		rd(mct_pkg::REG_HIGH_PRIO, {4'h0, UPLINK});
		frame(1'b1, UPLINK);
		frame(1'b1, FAR_VIOL);
		frame(1'b0, OUTAGE);
		frame(1'b0, OUTAGE);
		// Third push into a full queue pushes out the oldest word
		wr(mct_pkg::REG_HIGH_PRIO, {4'h0, UPLINK});
		wr(mct_pkg::REG_HIGH_PRIO, {4'h0, FAR_VIOL});
		wr(mct_pkg::REG_HIGH_PRIO, {4'h0, PWR_LOSS});
		wr(mct_pkg::REG_LOW_PRIO, {4'h0, PWR_LOSS});
		frame(1'b1, FAR_VIOL);
		frame(1'b1, PWR_LOSS);
		frame(1'b0, PWR_LOSS);
		wr(mct_pkg::REG_MASK, 8'h03);
		wr(mct_pkg::REG_CTRL, 8'h01);
		rd(mct_pkg::REG_CTRL, 8'h01);
		for (i = 0; i < 8 * MF && irq !== 1'b1; i++) begin
			@(posedge clock);
			#1;
		end
		chk8("irq", 8'h01, {7'h0, irq});
		chk8("tick", 8'h01, {7'h0, tick_irq});
		rd(mct_pkg::REG_STATUS, 8'h01);
		wr(mct_pkg::REG_STATUS, 8'h01);
		#1 chk8("irq", 8'h00, {7'h0, irq});
		wr(mct_pkg::REG_CTRL, 8'h00);
		wr(mct_pkg::REG_MASK, 8'h01);
		@(posedge clock);
		code_violation <= 1'b1;
		@(posedge clock);
		code_violation <= 1'b0;
		#1 chk8("err", 8'h01, {7'h0, rx_err});
		rd(mct_pkg::REG_STATUS, 8'h02);
		chk8("irq", 8'h00, {7'h0, irq});
		wr(mct_pkg::REG_MASK, 8'h03);
		#1 chk8("irq", 8'h01, {7'h0, irq});
		wr(mct_pkg::REG_STATUS, 8'h02);
		#1 chk8("irq", 8'h00, {7'h0, irq});
		wr(mct_pkg::REG_HIGH_PRIO, {4'h0, FAR_VIOL});
		frame(1'b1, FAR_VIOL);
		summarize();
	end
endmodule : mct_tx_selector_tb_top
